// >>> rtl/cai_pkg.sv
// Purpose: Constants for the per-channel alarm and interrupt status block
// Assumes: Four recovery channels, 8-bit register port on the host clock
// Notes: Offsets are the byte addresses of the host register port
// Behaviour
// - One status register per channel at 0x0A, 0x12, 0x1A and 0x22.
// - Bit 5 reads live lock loss: 0 locked, 1 out of lock.
// - Bit 4 reads live signal loss: 0 no alarm, 1 loss present.
// - Bit 1 sets on any lock status change, reads 0 otherwise.
// - Bit 0 sets on any signal-loss status change, reads 0 otherwise.
// - Lock change interrupts only when that channel's lock enable is set.
// - Signal change interrupts only when that channel's signal enable is set.
// - Status bits 7, 6, 3 and 2 always read 0.
// - Config bit 1 is the lock change interrupt enable, reset 0.
// - Config bit 0 is the signal change interrupt enable, reset 0.
package cai_pkg;

  localparam int CAI_NUM_CH = 4;
  localparam int CAI_AW = 8;
  localparam int CAI_DW = 8;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] CAI_CH0_CFG_OFS = 8'h09;
  localparam logic [7:0] CAI_CH1_CFG_OFS = 8'h11;
  localparam logic [7:0] CAI_CH2_CFG_OFS = 8'h19;
  localparam logic [7:0] CAI_CH3_CFG_OFS = 8'h21;
  localparam logic [7:0] CAI_CH0_STATUS_OFS = 8'h0A;
  localparam logic [7:0] CAI_CH1_STATUS_OFS = 8'h12;
  localparam logic [7:0] CAI_CH2_STATUS_OFS = 8'h1A;
  localparam logic [7:0] CAI_CH3_STATUS_OFS = 8'h22;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CAI_LOCK_LIVE_BIT = 5;
  localparam int CAI_SIGNAL_LIVE_BIT = 4;
  localparam int CAI_LOCK_FLAG_BIT = 1;
  localparam int CAI_SIGNAL_FLAG_BIT = 0;
  localparam int CAI_LOCK_IE_BIT = 1;
  localparam int CAI_SIGNAL_IE_BIT = 0;
  localparam int CAI_RATE_MSB = 5;
  localparam int CAI_RATE_LSB = 4;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] CAI_CFG_RESET = 8'h00;
  localparam logic [7:0] CAI_STATUS_RESET = 8'h00;
  localparam logic [7:0] CAI_UNMAPPED_DATA = 8'h00;
  localparam logic [1:0] CAI_RATE_RESET = 2'h0;

endpackage : cai_pkg

// >>> rtl/cai_chan_alarm.sv
// Purpose: One channel's live alarm copies and latched change flags
// Assumes: Alarm inputs are synchronous to clk_sys_i
// Notes: Live copies reset to 0, so an alarm already high flags a change
`timescale 1ns/100ps
module cai_chan_alarm (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic lock_lost_i,
  input wire logic signal_lost_i,
  input wire logic clear_on_read_i,
  output logic lock_lost_live_o,
  output logic signal_lost_live_o,
  output logic lock_change_flag_o,
  output logic signal_change_flag_o
);
  import cai_pkg::*;

  logic lock_live_reg;
  logic lock_live_next;
  logic sig_live_reg;
  logic sig_live_next;
  logic lock_flag_reg;
  logic lock_flag_next;
  logic sig_flag_reg;
  logic sig_flag_next;
  logic lock_change;
  logic sig_change;

  // ----------------------------------------------------------------------
  // Change detection and flags
  // ----------------------------------------------------------------------
  always_comb begin
    lock_live_next = lock_lost_i;
    sig_live_next = signal_lost_i;
    lock_change = lock_lost_i ^ lock_live_reg;
    sig_change = signal_lost_i ^ sig_live_reg;
    // Set beats clear so a change seen during the read is not lost
    lock_flag_next = (lock_flag_reg & ~clear_on_read_i) | lock_change;
    sig_flag_next = (sig_flag_reg & ~clear_on_read_i) | sig_change;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      lock_live_reg <= 1'b0;
      sig_live_reg <= 1'b0;
      lock_flag_reg <= 1'b0;
      sig_flag_reg <= 1'b0;
    end else begin
      lock_live_reg <= lock_live_next;
      sig_live_reg <= sig_live_next;
      lock_flag_reg <= lock_flag_next;
      sig_flag_reg <= sig_flag_next;
    end
  end

  assign lock_lost_live_o = lock_live_reg;
  assign signal_lost_live_o = sig_live_reg;
  assign lock_change_flag_o = lock_flag_reg;
  assign signal_change_flag_o = sig_flag_reg;

endmodule : cai_chan_alarm

// >>> rtl/cai_alarm_irq.sv
// Purpose: Four-channel alarm status, interrupt enables and interrupt output
// Assumes: Host register port is decoded from the serial host interface
// Notes: Read data and interrupt are registered, one cycle after the cause
`timescale 1ns/100ps
module cai_alarm_irq (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [cai_pkg::CAI_AW-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [cai_pkg::CAI_DW-1:0] reg_wdata_i,
  input wire logic [cai_pkg::CAI_NUM_CH-1:0] lock_lost_i,
  input wire logic [cai_pkg::CAI_NUM_CH-1:0] signal_lost_i,
  output logic [cai_pkg::CAI_DW-1:0] reg_rdata_o,
  output logic reg_rdata_valid_o,
  output logic [2*cai_pkg::CAI_NUM_CH-1:0] rate_sel_o,
  output logic irq_o
);
  import cai_pkg::*;

  // ----------------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------------
  // Returns {hit, channel} for the status registers
  function automatic logic [2:0] cai_status_slot(input logic [7:0] addr);
    logic [2:0] slot;
    slot = 3'h0;
    if (addr == CAI_CH0_STATUS_OFS) begin
      slot = 3'h4;
    end else if (addr == CAI_CH1_STATUS_OFS) begin
      slot = 3'h5;
    end else if (addr == CAI_CH2_STATUS_OFS) begin
      slot = 3'h6;
    end else if (addr == CAI_CH3_STATUS_OFS) begin
      slot = 3'h7;
    end
    return slot;
  endfunction : cai_status_slot

  // Returns {hit, channel} for the configuration registers
  function automatic logic [2:0] cai_cfg_slot(input logic [7:0] addr);
    logic [2:0] slot;
    slot = 3'h0;
    if (addr == CAI_CH0_CFG_OFS) begin
      slot = 3'h4;
    end else if (addr == CAI_CH1_CFG_OFS) begin
      slot = 3'h5;
    end else if (addr == CAI_CH2_CFG_OFS) begin
      slot = 3'h6;
    end else if (addr == CAI_CH3_CFG_OFS) begin
      slot = 3'h7;
    end
    return slot;
  endfunction : cai_cfg_slot

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [2:0] stat_slot;
  logic [2:0] cfg_slot;
  logic [CAI_NUM_CH-1:0] clear_on_read;
  logic [CAI_NUM_CH-1:0] lock_lost_live;
  logic [CAI_NUM_CH-1:0] signal_lost_live;
  logic [CAI_NUM_CH-1:0] lock_change_flag;
  logic [CAI_NUM_CH-1:0] signal_change_flag;
  logic [CAI_NUM_CH-1:0] lock_change_irq_enable_reg;
  logic [CAI_NUM_CH-1:0] lock_change_irq_enable_next;
  logic [CAI_NUM_CH-1:0] signal_change_irq_enable_reg;
  logic [CAI_NUM_CH-1:0] signal_change_irq_enable_next;
  logic [2*CAI_NUM_CH-1:0] rate_reg;
  logic [2*CAI_NUM_CH-1:0] rate_next;
  logic [CAI_DW-1:0] rdata_reg;
  logic [CAI_DW-1:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic irq_reg;
  logic irq_next;

  assign stat_slot = cai_status_slot(reg_addr_i);
  assign cfg_slot = cai_cfg_slot(reg_addr_i);

  // ----------------------------------------------------------------------
  // Per-channel alarm cells
  // ----------------------------------------------------------------------
  for (genvar ch = 0; ch < CAI_NUM_CH; ch++) begin : g_chan
    // Clear pulse only for a read of this channel's own status word
    assign clear_on_read[ch] = reg_rd_i & stat_slot[2] &
                               (stat_slot[1:0] == 2'(ch));

    cai_chan_alarm u_chan (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .lock_lost_i(lock_lost_i[ch]),
      .signal_lost_i(signal_lost_i[ch]),
      .clear_on_read_i(clear_on_read[ch]),
      .lock_lost_live_o(lock_lost_live[ch]),
      .signal_lost_live_o(signal_lost_live[ch]),
      .lock_change_flag_o(lock_change_flag[ch]),
      .signal_change_flag_o(signal_change_flag[ch])
    );
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_comb begin
    lock_change_irq_enable_next = lock_change_irq_enable_reg;
    signal_change_irq_enable_next = signal_change_irq_enable_reg;
    rate_next = rate_reg;
    if (reg_wr_i && cfg_slot[2]) begin
      lock_change_irq_enable_next[cfg_slot[1:0]] =
        reg_wdata_i[CAI_LOCK_IE_BIT];
      signal_change_irq_enable_next[cfg_slot[1:0]] =
        reg_wdata_i[CAI_SIGNAL_IE_BIT];
      rate_next[2*cfg_slot[1:0] +: 2] =
        reg_wdata_i[CAI_RATE_MSB:CAI_RATE_LSB];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      lock_change_irq_enable_reg <= {CAI_NUM_CH{CAI_CFG_RESET[CAI_LOCK_IE_BIT]}};
      signal_change_irq_enable_reg <=
        {CAI_NUM_CH{CAI_CFG_RESET[CAI_SIGNAL_IE_BIT]}};
      rate_reg <= {CAI_NUM_CH{CAI_RATE_RESET}};
    end else begin
      lock_change_irq_enable_reg <= lock_change_irq_enable_next;
      signal_change_irq_enable_reg <= signal_change_irq_enable_next;
      rate_reg <= rate_next;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Status read returns flags as they stood before the clear takes hold
  always_comb begin
    rdata_next = CAI_UNMAPPED_DATA;
    rvalid_next = reg_rd_i;
    if (reg_rd_i) begin
      if (stat_slot[2]) begin
        rdata_next = CAI_STATUS_RESET;
        rdata_next[CAI_LOCK_LIVE_BIT] = lock_lost_live[stat_slot[1:0]];
        rdata_next[CAI_SIGNAL_LIVE_BIT] =
          signal_lost_live[stat_slot[1:0]];
        rdata_next[CAI_LOCK_FLAG_BIT] =
          lock_change_flag[stat_slot[1:0]];
        rdata_next[CAI_SIGNAL_FLAG_BIT] =
          signal_change_flag[stat_slot[1:0]];
      end else if (cfg_slot[2]) begin
        rdata_next = CAI_CFG_RESET;
        rdata_next[CAI_LOCK_IE_BIT] =
          lock_change_irq_enable_reg[cfg_slot[1:0]];
        rdata_next[CAI_SIGNAL_IE_BIT] =
          signal_change_irq_enable_reg[cfg_slot[1:0]];
        rdata_next[CAI_RATE_MSB:CAI_RATE_LSB] =
          rate_reg[2*cfg_slot[1:0] +: 2];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata_reg <= CAI_UNMAPPED_DATA;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------------
  // Registered to keep the pin glitch free; costs one cycle of latency
  always_comb begin
    irq_next = |((lock_change_flag & lock_change_irq_enable_reg) |
                 (signal_change_flag & signal_change_irq_enable_reg));
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign reg_rdata_valid_o = rvalid_reg;
  assign rate_sel_o = rate_reg;
  assign irq_o = irq_reg;

endmodule : cai_alarm_irq

// >>> tb/cai_alarm_irq_monitor.sv
// Purpose: Port checker for the alarm status block
// Assumes: Alarm inputs stay still while reset is high
// Notes: Keeps its own copy of the interrupt enables
`timescale 1ns/100ps
module cai_alarm_irq_monitor (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [3:0] lock_lost_i,
  input wire logic [3:0] signal_lost_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rdata_valid_o,
  input wire logic [7:0] rate_sel_o,
  input wire logic irq_o
);
  logic [7:0] ie_reg;
  logic [7:0] ie_next;
  logic [2:0] sel;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // Copy of enables: irq gating cannot be judged without them
  always_comb begin
    sel = reg_addr_i[5:3] - 3'h1;
    ie_next = ie_reg;
    if (reg_wr_i && reg_addr_i[2:0] == 3'h1 && reg_addr_i[7:6] == 2'h0
        && reg_addr_i[5:3] != 3'h0 && reg_addr_i[5:3] < 3'h5)
      ie_next[{sel[1:0], 1'b0} +: 2] = reg_wdata_i[1:0];
    if (sys_rst_i)
      ie_next = 8'h00;
  end
  always_ff @(posedge clk_sys_i) ie_reg <= ie_next;
  sequence s_q0;
    !$changed(lock_lost_i[0]) && !$changed(signal_lost_i[0]);
  endsequence
  sequence s_rd0;
    reg_rd_i && reg_addr_i == 8'h0A ##0 s_q0;
  endsequence
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  AST_RD_VALID: assert property (reg_rd_i |=> reg_rdata_valid_o)
    else $error("read not answered");
  AST_RSVD: assert property (reg_rdata_valid_o |->
    !(|reg_rdata_o[7:6]) && !(|reg_rdata_o[3:2]))
    else $error("unused status bits set");
  AST_LIVE: assert property (reg_rd_i && reg_addr_i == 8'h0A |=>
    reg_rdata_o[5:4] == {$past(lock_lost_i[0], 2), $past(signal_lost_i[0], 2)})
    else $error("live bits wrong");
  AST_FLAG: assert property ($changed(lock_lost_i[1]) ##1
    (reg_rd_i && reg_addr_i == 8'h12) |=> reg_rdata_o[1])
    else $error("lock change not flagged");
  AST_CLR: assert property (s_rd0 ##1 s_q0 ##1 s_rd0 |=>
    reg_rdata_o[1:0] == 2'h0) else $error("flags not cleared by read");
  AST_IRQ_LOCK: assert property (ie_reg[5] && !reg_wr_i &&
    $changed(lock_lost_i[2]) |-> ##2 irq_o) else $error("lock irq missing");
  AST_IRQ_SIG: assert property (ie_reg[4] && !reg_wr_i &&
    $changed(signal_lost_i[2]) |-> ##2 irq_o)
    else $error("signal irq missing");
  AST_MASKED: assert property (ie_reg == 8'h00 && !reg_wr_i |=> !irq_o)
    else $error("irq while masked");
  AST_HOLD: assert property ((!reg_rd_i && !reg_wr_i) [*2] ##0 irq_o
    |=> irq_o) else $error("irq dropped without a read");
endmodule : cai_alarm_irq_monitor

// >>> tb/cai_alarm_irq_bench.sv
// Purpose: Self-checking bench for the alarm status block
// Assumes: 20 MHz clock, inputs driven 2 ns after the edge
// Notes: Table rows cover config and refused writes
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
  n_errors++; $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module cai_alarm_irq_bench;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [3:0] lock_lost_i = 4'h0;
  logic [3:0] signal_lost_i = 4'h0;
  logic [7:0] reg_rdata_o;
  logic reg_rdata_valid_o;
  logic [7:0] rate_sel_o;
  logic irq_o;
  logic [7:0] got;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  // Row: address, write data, expected read back
  logic [23:0] rows [6] = '{24'h09FF33, 24'h113232, 24'h19C202,
    24'h211111, 24'h0AFF00, 24'h30FF00};
  cai_alarm_irq dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .lock_lost_i(lock_lost_i),
    .signal_lost_i(signal_lost_i), .reg_rdata_o(reg_rdata_o),
    .reg_rdata_valid_o(reg_rdata_valid_o), .rate_sel_o(rate_sel_o),
    .irq_o(irq_o));
  initial forever #25 clk_sys_i = ~clk_sys_i;
  // Run needs about 80 cycles; the ceiling leaves ample margin
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      close_out;
    end
  end
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    tick(1);
    reg_wr_i = 1'b0;
  endtask : wr
  // Flip lets a signal change land on the same edge as the read
  task automatic rd(input logic [7:0] a, input logic [3:0] flip);
    tick(1);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    signal_lost_i = signal_lost_i ^ flip;
    tick(1);
    reg_rd_i = 1'b0;
    got = reg_rdata_o;
    `CHK("valid", 1'b1, reg_rdata_valid_o)
  endtask : rd
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  initial begin
    tick(3);
    sys_rst_i = 1'b0;
    for (int i = 0; i < 6; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], 4'h0);
      `CHK("row", rows[i][7:0], got)
    end
    `CHK("rate", 8'h4F, rate_sel_o)
    lock_lost_i[2] = 1'b1;
    tick(2);
    `CHK("irq lock", 1'b1, irq_o)
    rd(8'h1A, 4'h0);
    `CHK("ch2 st", 8'h22, got)
    tick(1);
    `CHK("irq drop", 1'b0, irq_o)
    rd(8'h1A, 4'h0);
    `CHK("ch2 clr", 8'h20, got)
    signal_lost_i[2] = 1'b1;
    tick(3);
    `CHK("irq mask", 1'b0, irq_o)
    wr(8'h19, 8'h01);
    tick(1);
    `CHK("irq en", 1'b1, irq_o)
    rd(8'h1A, 4'h0);
    `CHK("ch2 sig", 8'h31, got)
    rd(8'h1A, 4'h4);
    `CHK("flags", 8'h00, got & 8'h03)
    rd(8'h1A, 4'h0);
    `CHK("kept", 8'h21, got)
    for (int c = 0; c < 4; c++) if (c != 2) begin
      lock_lost_i[c] = 1'b1;
      signal_lost_i[c] = 1'b1;
      rd(8'h0A + 8'(8 * c), 4'h0);
      `CHK("both", 8'h33, got)
      rd(8'h0A + 8'(8 * c), 4'h0);
      `CHK("again", 8'h30, got)
    end
    // Interrupt lags the last clearing read by one cycle
    tick(1);
    `CHK("irq idle", 1'b0, irq_o)
    lock_lost_i = 4'h0;
    signal_lost_i = 4'h0;
    sys_rst_i = 1'b1;
    tick(3);
    sys_rst_i = 1'b0;
    `CHK("rst rate", 8'h00, rate_sel_o)
    for (int c = 0; c < 8; c++) begin
      rd(8'h09 + 8'(8 * (c / 2) + c % 2), 4'h0);
      `CHK("rst reg", 8'h00, got)
    end
    `CHK("rst irq", 1'b0, irq_o)
    close_out;
  end
endmodule : cai_alarm_irq_bench
bind cai_alarm_irq cai_alarm_irq_monitor mon (.clk_sys_i(clk_sys_i),
  .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .lock_lost_i(lock_lost_i), .signal_lost_i(signal_lost_i),
  .reg_rdata_o(reg_rdata_o), .reg_rdata_valid_o(reg_rdata_valid_o),
  .rate_sel_o(rate_sel_o), .irq_o(irq_o));
